// [acts_pkg.sv]
package acts_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_MODE      = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
   localparam logic [7:0] OFS_START_DLY = 8'h14;

   // control register fields
   localparam int CTRL_RUN_POS    = 0;
   localparam int CTRL_ENABLE_POS = 1;
   localparam int CTRL_HWTRIG_POS = 2;
   localparam int CTRL_SEQ_POS    = 3;

   // mode register fields
   localparam int MODE_RATIO_LSB = 0;
   localparam int MODE_VOLT_LSB  = 3;
   localparam int MODE_SPEED_POS = 5;

   // interrupt status / mask bits
   localparam int IRQ_DONE_POS    = 0;
   localparam int IRQ_BADSET_POS  = 1;
   localparam int IRQ_REFUSED_POS = 2;
   localparam int IRQ_BITS        = 3;

   // reset values
   localparam logic [4:0]  CTRL_RESET      = 5'h00;
   localparam logic [5:0]  MODE_RESET      = 6'h00;
   localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;
   localparam logic [15:0] START_DLY_RESET = 16'h0010;

   // timing
   localparam int CLK_PERIOD_NS    = 20;
   localparam int STOP_SETTLE_NS   = 200;
   localparam int STOP_SETTLE_CYC  = (STOP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] SLOTS_PER_CONV = 3'h4;
   localparam logic [2:0] SEQ_DELAY_CUT  = 3'h3;

   typedef struct packed {
      logic [5:0] div;
      logic [2:0] wait_cyc;
      logic [7:0] conv_cyc;
      logic [2:0] delay_cyc;
      logic       ok;
   } acts_timing_type;

   typedef struct packed {
      logic       speed;
      logic [2:0] ratio;
      logic [1:0] volt;
   } acts_mode_type;

   localparam acts_timing_type TIM_NORM_D32 = '{6'h20, 3'h4, 8'h40, 3'h4, 1'b1};
   localparam acts_timing_type TIM_NORM_D16 = '{6'h10, 3'h4, 8'h40, 3'h4, 1'b1};
   localparam acts_timing_type TIM_LCS_D1   = '{6'h01, 3'h6, 8'hb5, 3'h4, 1'b1};
   localparam acts_timing_type TIM_LV_D32   = '{6'h20, 3'h4, 8'h50, 3'h4, 1'b1};
   localparam acts_timing_type TIM_LV_D16   = '{6'h10, 3'h4, 8'h50, 3'h4, 1'b1};
   localparam acts_timing_type TIM_BAD      = '{6'h20, 3'h4, 8'h40, 3'h4, 1'b0};

   localparam logic [1:0] VOLT_NORMAL = 2'h0;
   localparam logic [1:0] VOLT_LOW    = 2'h2;

   function automatic acts_timing_type acts_lookup(input acts_mode_type m);
      acts_timing_type t;
      t = TIM_BAD;
      case ({m.speed, m.ratio, m.volt})
         {1'b0, 3'h0, VOLT_NORMAL}: t = TIM_NORM_D32;
         {1'b0, 3'h1, VOLT_NORMAL}: t = TIM_NORM_D16;
         {1'b1, 3'h5, VOLT_NORMAL}: t = TIM_LCS_D1;
         {1'b0, 3'h0, VOLT_LOW}:    t = TIM_LV_D32;
         {1'b0, 3'h1, VOLT_LOW}:    t = TIM_LV_D16;
         default:                   t = TIM_BAD;
      endcase
      return t;
   endfunction

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_WAIT  = 5'h04,
      ST_SLOT  = 5'h08,
      ST_DELAY = 5'h10
   } acts_state_type;

endpackage

// [acts_prescaler.sv]
`timescale 1ns/1ps
module acts_prescaler #(
   parameter int DIV_W = 6
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // control
   input  wire logic             restart,
   input  wire logic [DIV_W-1:0] div,
   // conversion clock enable
   output logic                  tick
);

   initial begin
      if (DIV_W < 1) begin
         $error("acts_prescaler: DIV_W must be at least 1");
      end
   end

   logic [DIV_W-1:0] cnt_reg;
   logic             last;

   assign last = (cnt_reg >= div - DIV_W'(1));

   always_ff @(posedge clk) begin
      if (reset || restart || last) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + DIV_W'(1);
      end
   end

   // restart realigns the divider so each phase starts on a full period
   always_ff @(posedge clk) begin
      if (reset || restart) begin
         tick <= 1'b0;
      end else begin
         tick <= last;
      end
   end

endmodule

// [acts_timing.sv]
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - total time is wait, four slots, delay
// - normal ratio 000 divides by 32, 4/64/4
// - normal ratio 001 divides by 16, 4/64/4
// - speed bit, ratio 101: undivided, 6/181/4
// - low voltage ratio 001: by 16, 4/80/4
// - hardware sequential repeats skip start, wait; later software sequential scans skip start only
// - sequential mode shortens delay by three cycles
// - first conversion adds the start time
// - hardware mode: wait counts from trigger detect
// - software mode: wait counts from run set
module acts_timing (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // hardware trigger pin
   input  wire logic        hw_trigger,
   // converter core
   output logic             converting,
   output logic [1:0]       slot_index,
   output logic             slot_end,
   output logic             conv_end,
   // interrupt
   output logic             irq
);

   logic [4:0]                 ctrl_reg;
   acts_pkg::acts_mode_type    mode_reg;
   logic [15:0]                start_dly_reg;
   logic [acts_pkg::IRQ_BITS-1:0] irq_stat_reg;
   logic [acts_pkg::IRQ_BITS-1:0] irq_mask_reg;
   acts_pkg::acts_state_type   state_reg;
   acts_pkg::acts_state_type   state_next;
   logic [15:0]                cnt_reg;
   logic [1:0]                 slot_reg;
   logic                       first_reg;
   logic                       skip_reg;
   logic [4:0]                 settle_reg;
   logic                       trig_meta_reg;
   logic                       trig_sync_reg;
   logic                       trig_old_reg;
   logic                       tick;
   logic                       restart;
   acts_pkg::acts_timing_type  tim;

   logic       run;
   logic       enable;
   logic       hw_mode;
   logic       seq_mode;
   logic       trig_edge;
   logic       wr_access;
   logic       rd_access;
   logic       wr_ctrl;
   logic       wr_mode;
   logic       mode_refused;
   logic       run_set;
   logic       go;
   logic       bad_start;
   logic       stop;
   logic       phase_last;
   logic       delay_end;
   logic       run_clear;
   logic [2:0] delay_len;
   logic       mapped;

   assign run      = ctrl_reg[acts_pkg::CTRL_RUN_POS];
   assign enable   = ctrl_reg[acts_pkg::CTRL_ENABLE_POS];
   assign hw_mode  = ctrl_reg[acts_pkg::CTRL_HWTRIG_POS];
   assign seq_mode = ctrl_reg[acts_pkg::CTRL_SEQ_POS];
   assign tim      = acts_pkg::acts_lookup(mode_reg);

   // apb: access phase lasts two cycles, pready rises in the second
   assign wr_access = psel && penable && pready && pwrite;
   assign rd_access = psel && penable && !pready && !pwrite;
   assign wr_ctrl   = wr_access && (paddr == acts_pkg::OFS_CTRL);
   assign wr_mode   = wr_access && (paddr == acts_pkg::OFS_MODE);

   always_comb begin
      case (paddr)
         acts_pkg::OFS_CTRL, acts_pkg::OFS_MODE, acts_pkg::OFS_STATUS,
         acts_pkg::OFS_IRQ_STAT, acts_pkg::OFS_IRQ_MASK,
         acts_pkg::OFS_START_DLY: mapped = 1'b1;
         default:                 mapped = 1'b0;
      endcase
   end

   // a mode write while running, enabled or still settling is dropped
   assign mode_refused = wr_mode && (run || enable || settle_reg != 5'h00);

   assign run_set = wr_ctrl && pwdata[acts_pkg::CTRL_RUN_POS] && !run;
   assign stop    = !run || !enable;

   // trigger pin is asynchronous: two flops before the edge detector
   always_ff @(posedge clk) begin
      if (reset) begin
         trig_meta_reg <= 1'b0;
         trig_sync_reg <= 1'b0;
         trig_old_reg  <= 1'b0;
      end else begin
         trig_meta_reg <= hw_trigger;
         trig_sync_reg <= trig_meta_reg;
         trig_old_reg  <= trig_sync_reg;
      end
   end

   assign trig_edge = trig_sync_reg && !trig_old_reg;
   // start request: trigger edge in hardware mode, run set in software mode
   always_comb begin
      if (hw_mode) begin
         go = trig_edge && run && enable;
      end else begin
         go = run_set && pwdata[acts_pkg::CTRL_ENABLE_POS]
              && !pwdata[acts_pkg::CTRL_HWTRIG_POS];
      end
   end

   // an unlisted setting never starts a conversion
   assign bad_start = go && !tim.ok && state_reg == acts_pkg::ST_IDLE;

   assign delay_len  = seq_mode ? tim.delay_cyc - acts_pkg::SEQ_DELAY_CUT
                                : tim.delay_cyc;
   assign phase_last = tick && (
      (state_reg == acts_pkg::ST_WAIT  && cnt_reg == 16'(tim.wait_cyc) - 16'h1) ||
      (state_reg == acts_pkg::ST_SLOT  && cnt_reg == 16'(tim.conv_cyc) - 16'h1) ||
      (state_reg == acts_pkg::ST_DELAY && cnt_reg == 16'(delay_len) - 16'h1));
   assign delay_end  = phase_last && state_reg == acts_pkg::ST_DELAY;

   // software one-shot ends by dropping the run bit
   assign run_clear = delay_end && !hw_mode && !seq_mode;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         acts_pkg::ST_IDLE: begin
            if (go && tim.ok) begin
               if (skip_reg) begin
                  state_next = acts_pkg::ST_SLOT;
               end else if (first_reg || run_set) begin
                  state_next = acts_pkg::ST_START;
               end else begin
                  state_next = acts_pkg::ST_WAIT;
               end
            end
         end
         acts_pkg::ST_START: begin
            if (cnt_reg >= start_dly_reg) begin
               state_next = acts_pkg::ST_WAIT;
            end
         end
         acts_pkg::ST_WAIT: begin
            if (phase_last) begin
               state_next = acts_pkg::ST_SLOT;
            end
         end
         acts_pkg::ST_SLOT: begin
            if (phase_last && slot_reg == 2'(acts_pkg::SLOTS_PER_CONV - 3'h1)) begin
               state_next = acts_pkg::ST_DELAY;
            end
         end
         acts_pkg::ST_DELAY: begin
            if (delay_end) begin
               // software sequential runs on at once, still with its wait
               if (seq_mode && !hw_mode) begin
                  state_next = acts_pkg::ST_WAIT;
               end else begin
                  state_next = acts_pkg::ST_IDLE;
               end
            end
         end
         default: state_next = acts_pkg::ST_IDLE;
      endcase
      if (stop && state_reg != acts_pkg::ST_IDLE) begin
         state_next = acts_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= acts_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // divider restarts on every phase entry so phases are whole fad periods
   assign restart = (state_next != state_reg) || (state_reg == acts_pkg::ST_START);

   acts_prescaler #(
      .DIV_W(6)
   ) u_prescaler (
      .clk    (clk),
      .reset  (reset),
      .restart(restart),
      .div    (tim.div),
      .tick   (tick)
   );

   // phase counter: system clocks in the start phase, fad ticks elsewhere
   always_ff @(posedge clk) begin
      if (reset || state_next != state_reg || phase_last) begin
         cnt_reg <= 16'h0000;
      end else if (state_reg == acts_pkg::ST_START || tick) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || state_reg != acts_pkg::ST_SLOT) begin
         slot_reg <= 2'h0;
      end else if (phase_last) begin
         slot_reg <= slot_reg + 2'h1;
      end
   end

   // start time only before the first conversion after run is set
   always_ff @(posedge clk) begin
      if (reset) begin
         first_reg <= 1'b0;
      end else if (run_set) begin
         first_reg <= 1'b1;
      end else if (state_reg == acts_pkg::ST_START) begin
         first_reg <= 1'b0;
      end
   end

   // hardware sequential repeats go straight to the slots
   always_ff @(posedge clk) begin
      if (reset || stop || !seq_mode || !hw_mode) begin
         skip_reg <= 1'b0;
      end else if (delay_end) begin
         skip_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         settle_reg <= 5'h00;
      end else if (run || enable) begin
         settle_reg <= 5'(acts_pkg::STOP_SETTLE_CYC);
      end else if (settle_reg != 5'h00) begin
         settle_reg <= settle_reg - 5'h01;
      end
   end

   // control: a software write wins over the hardware run clear
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= acts_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= pwdata[4:0];
      end else if (run_clear) begin
         ctrl_reg[acts_pkg::CTRL_RUN_POS] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mode_reg <= acts_pkg::MODE_RESET;
      end else if (wr_mode && !mode_refused) begin
         mode_reg.speed <= pwdata[acts_pkg::MODE_SPEED_POS];
         mode_reg.ratio <= pwdata[acts_pkg::MODE_RATIO_LSB +: 3];
         mode_reg.volt  <= pwdata[acts_pkg::MODE_VOLT_LSB +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         start_dly_reg <= acts_pkg::START_DLY_RESET;
      end else if (wr_access && paddr == acts_pkg::OFS_START_DLY) begin
         start_dly_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_mask_reg <= acts_pkg::IRQ_MASK_RESET;
      end else if (wr_access && paddr == acts_pkg::OFS_IRQ_MASK) begin
         irq_mask_reg <= pwdata[acts_pkg::IRQ_BITS-1:0];
      end
   end

   // sticky events, write one to clear; a new event beats the clear
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_stat_reg <= '0;
      end else begin
         if (wr_access && paddr == acts_pkg::OFS_IRQ_STAT) begin
            irq_stat_reg <= irq_stat_reg & ~pwdata[acts_pkg::IRQ_BITS-1:0];
         end
         if (delay_end) begin
            irq_stat_reg[acts_pkg::IRQ_DONE_POS] <= 1'b1;
         end
         if (bad_start) begin
            irq_stat_reg[acts_pkg::IRQ_BADSET_POS] <= 1'b1;
         end
         if (mode_refused) begin
            irq_stat_reg[acts_pkg::IRQ_REFUSED_POS] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // core strobes, registered
   always_ff @(posedge clk) begin
      if (reset) begin
         converting <= 1'b0;
         slot_index <= 2'h0;
         slot_end   <= 1'b0;
         conv_end   <= 1'b0;
      end else begin
         converting <= state_reg == acts_pkg::ST_SLOT;
         slot_index <= slot_reg;
         slot_end   <= phase_last && state_reg == acts_pkg::ST_SLOT;
         conv_end   <= delay_end;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && penable && !pready && !mapped;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (rd_access) begin
         case (paddr)
            acts_pkg::OFS_CTRL:      prdata <= {27'h0, ctrl_reg};
            acts_pkg::OFS_MODE:      prdata <= {26'h0, mode_reg.speed, mode_reg.volt,
                                                mode_reg.ratio};
            acts_pkg::OFS_STATUS:    prdata <= {22'h0, (settle_reg != 5'h00), tim.ok,
                                                slot_reg, 1'b0, state_reg};
            acts_pkg::OFS_IRQ_STAT:  prdata <= {29'h0, irq_stat_reg};
            acts_pkg::OFS_IRQ_MASK:  prdata <= {29'h0, irq_mask_reg};
            acts_pkg::OFS_START_DLY: prdata <= {16'h0, start_dly_reg};
            default:                 prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// [acts_timing_sva.sv]
`timescale 1ns/1ps
module acts_timing_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // converter core
   input wire logic        converting,
   input wire logic        slot_end,
   input wire logic        conv_end
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // a completed write may abort a conversion, so it restarts the slot count
   logic [2:0] slot_cnt;
   always_ff @(posedge clk) begin
      if (reset || conv_end || (pready && pwrite)) begin
         slot_cnt <= 3'h0;
      end else if (slot_end) begin
         slot_cnt <= slot_cnt + 3'h1;
      end
   end

   property p_four_slots;
      conv_end |-> slot_cnt == 3'h4;
   endproperty
   a_four_slots: assert property (p_four_slots)
      else $error("conversion ended without four slots");
   property p_conv_idle;
      conv_end |-> !converting;
   endproperty
   a_conv_idle: assert property (p_conv_idle)
      else $error("conversion end while slots still running");
   property p_slot_gap;
      slot_end |=> !slot_end [*8];
   endproperty
   a_slot_gap: assert property (p_slot_gap)
      else $error("slot end pulses too close");
   property p_conv_pulse;
      conv_end |=> !conv_end;
   endproperty
   a_conv_pulse: assert property (p_conv_pulse)
      else $error("conversion end longer than one cycle");
   property p_pready_pulse;
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse)
      else $error("pready longer than one cycle");
   property p_pready_access;
      pready |-> psel && penable && $past(penable);
   endproperty
   a_pready_access: assert property (p_pready_access)
      else $error("pready outside second access cycle");
   property p_err_pready;
      pslverr |-> pready;
   endproperty
   a_err_pready: assert property (p_err_pready)
      else $error("pslverr without pready");
   property p_rdata_hold;
      $changed(prdata) |-> $past(penable) && !$past(pwrite);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed outside a read");
endmodule

bind acts_timing acts_timing_sva i_sva (
   .clk, .reset, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
   .converting, .slot_end, .conv_end
);

// [acts_timing_test.sv]
`timescale 1ns/1ps
module acts_timing_test;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        hw_trigger = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, converting, slot_end, conv_end, irq;
   logic [1:0]  slot_index;
   logic [31:0] rd;
   logic        er;
   int          fail_count = 0;
   int          num_checks = 0;
   int          n, lo;
   logic [5:0]  md [5] = '{6'h00, 6'h01, 6'h25, 6'h10, 6'h11};
   int          dv [5] = '{32, 16, 1, 32, 16};
   int          wt [5] = '{4, 4, 6, 4, 4};
   int          cv [5] = '{64, 64, 181, 80, 80};
   // start delay reset value plus the extra cycle of the start phase
   localparam int SD = 17;

   always #10 clk = ~clk;

   acts_timing i_dut (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hw_trigger(hw_trigger), .converting(converting),
      .slot_index(slot_index), .slot_end(slot_end), .conv_end(conv_end), .irq(irq)
   );

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         complete_run;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, rd, exp);
   endtask

   // bounded wait for conv_end (sel 1) or slot_end (sel 0), cycles land in n
   task automatic wait_ev(input logic sel, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((sel ? conv_end : slot_end) !== 1'b1 && n < lim);
      if (n >= lim) begin
         fail_count++;
         complete_run;
      end
   endtask

   task automatic rng(input string nm, input int hi);
      check(nm, (n >= lo && n <= hi) ? lo : n, lo);
   endtask

   // mode may only change once stopped and settled
   task automatic stop_set(input logic [5:0] m);
      wr(acts_pkg::OFS_CTRL, 32'h0);
      repeat (acts_pkg::STOP_SETTLE_CYC + 2) @(posedge clk);
      wr(acts_pkg::OFS_MODE, {26'h0, m});
   endtask

   task automatic trig;
      @(posedge clk);
      hw_trigger <= 1'b1;
      repeat (2) @(posedge clk);
      hw_trigger <= 1'b0;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rdc("ctrl", acts_pkg::OFS_CTRL, 32'h0);
      rdc("mode", acts_pkg::OFS_MODE, 32'h0);
      rdc("mask", acts_pkg::OFS_IRQ_MASK, 32'h0);
      rdc("start delay", acts_pkg::OFS_START_DLY, 32'h10);
      rdc("irq stat", acts_pkg::OFS_IRQ_STAT, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped err", {31'h0, er}, 32'h1);
      $display("test reset values done");
      wr(acts_pkg::OFS_IRQ_MASK, 32'h1);
      for (int i = 0; i < 5; i++) begin
         stop_set(md[i]);
         rdc("mode", acts_pkg::OFS_MODE, {26'h0, md[i]});
         lo = SD + (wt[i] + 4 * cv[i] + 4) * dv[i];
         wr(acts_pkg::OFS_CTRL, 32'h3);
         wait_ev(1'b1, lo + 300);
         rng("conv time", lo + 12 + 4 * dv[i]);
         repeat (2) @(posedge clk);
         check("irq done", {31'h0, irq}, 32'h1);
         wr(acts_pkg::OFS_IRQ_STAT, 32'h1);
         repeat (2) @(posedge clk);
         check("irq cleared", {31'h0, irq}, 32'h0);
         $display("test setting %0d done in %0d cycles", i, n);
      end
      stop_set(6'h07);
      wr(acts_pkg::OFS_CTRL, 32'h3);
      repeat (100) @(posedge clk);
      check("no start", {31'h0, converting}, 32'h0);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(acts_pkg::OFS_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clk);
      check("irq bad set", {31'h0, irq}, 32'h1);
      rdc("irq stat", acts_pkg::OFS_IRQ_STAT, 32'h2);
      wr(acts_pkg::OFS_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      $display("test prohibited setting done");
      stop_set(6'h25);
      wr(acts_pkg::OFS_CTRL, 32'h2);
      wr(acts_pkg::OFS_MODE, 32'h01);
      rdc("mode kept", acts_pkg::OFS_MODE, 32'h25);
      wr(acts_pkg::OFS_CTRL, 32'h0);
      wr(acts_pkg::OFS_MODE, 32'h01);
      rdc("mode kept", acts_pkg::OFS_MODE, 32'h25);
      rdc("irq stat", acts_pkg::OFS_IRQ_STAT, 32'h4);
      wr(acts_pkg::OFS_IRQ_STAT, 32'h4);
      $display("test refused mode write done");
      wr(acts_pkg::OFS_CTRL, 32'hb);
      wait_ev(1'b1, 2000);
      wait_ev(1'b1, 2000);
      lo = 731;
      rng("seq period", 743);
      wait_ev(1'b0, 400);
      wait_ev(1'b0, 400);
      lo = 181;
      rng("slot length", 183);
      check("slot index", {30'h0, slot_index}, 32'h1);
      wr(acts_pkg::OFS_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      check("aborted", {31'h0, converting}, 32'h0);
      $display("test software sequential done");
      wr(acts_pkg::OFS_CTRL, 32'hf);
      trig;
      wait_ev(1'b1, 2000);
      lo = SD + 731;
      rng("hw first", SD + 745);
      trig;
      wait_ev(1'b1, 2000);
      lo = 725;
      rng("hw repeat", 730);
      wr(acts_pkg::OFS_CTRL, 32'h0);
      $display("test hardware sequential done");
      complete_run;
   end
endmodule
